// File: seq_consts.svh
/*
  numeric constants of the supply sequencing engine: sizes, field codes
  and timing counts. assumes a 10 MHz mclk.
*/
`ifndef SEQ_CONSTS_SVH
`define SEQ_CONSTS_SVH

`define NUM_STATES 63
`define ST_IDX_W 6
`define NUM_IN 10
`define NUM_OUT 10
`define NUM_HV_OUT 6
`define SEL_W 4
`define DLY_W 16
`define SRC_W 2
`define STYLE_W 3

`define MCLK_KHZ 10000
`define TICK_US 10
`define TICK_CYC (`TICK_US * `MCLK_KHZ / 1000)
`define MAX_DLY_MS 400
`define MAX_DLY_TICKS (`MAX_DLY_MS * 1000 / `TICK_US)
`define AUXCLK_KHZ 100
`define AUXCLK_HALF (`MCLK_KHZ / (2 * `AUXCLK_KHZ))
`define STEP_MAX_US 20
`define STEP_MAX_CYC (`STEP_MAX_US * `MCLK_KHZ / 1000)
`define LOAD_CYC 2

`define SEL_WARN 4'hA
`define SRC_ENGINE 2'h0
`define SRC_BUS 2'h1
`define SRC_CLK 2'h2
`define FIRST_STATE 6'h00

`endif

// File: seq_pkg.sv
/*
  types of the supply sequencing engine: state definition word, drive
  styles and engine phases. assumes seq_consts.svh is on the include path.
*/
`include "seq_consts.svh"

package seq_pkg;

    typedef struct packed {
        logic [`NUM_OUT-1:0] out_levels;
        logic [`ST_IDX_W-1:0] seq_next;
        logic [`SEL_W-1:0] seq_sel;
        logic seq_pol;
        logic [`DLY_W-1:0] seq_dly;
        logic tmo_en;
        logic [`ST_IDX_W-1:0] tmo_next;
        logic [`DLY_W-1:0] tmo_dly;
        logic [`ST_IDX_W-1:0] mon_next;
        logic [`NUM_IN-1:0] mon_mask;
        logic [`NUM_IN-1:0] mon_expect;
        logic mon_warn_en;
        logic latch_en;
    } state_def_t;

    typedef enum logic [`STYLE_W-1:0] {
        DRV_WEAK_PD,
        DRV_OPEN_DRAIN,
        DRV_WEAK_VDD,
        DRV_STRONG_VDD,
        DRV_WEAK_VP,
        DRV_STRONG_VP,
        DRV_STRONG_PD,
        DRV_PUMP
    } drive_style_t;

    typedef enum logic [1:0] {
        ENG_OFF,
        ENG_CFG,
        ENG_LOAD,
        ENG_RUN
    } engine_st_t;

endpackage

// File: driver_output_mux.sv
/*
  one driver output: picks the data source and works out the pin enable
  from the drive style. purely combinational; the caller registers it.
*/
`timescale 1ns/1ps
`include "seq_consts.svh"

module driver_output_mux (
    // selection
    input wire logic [`SRC_W-1:0] src_sel,
    input wire seq_pkg::drive_style_t style,
    input wire logic hv_ok,
    // data sources
    input wire logic se_bit,
    input wire logic bus_bit,
    input wire logic clk_bit,
    // result
    output logic level,
    output logic oe,
    output seq_pkg::drive_style_t style_eff
);
    import seq_pkg::*;

    always_comb begin
        unique case (src_sel)
            `SRC_ENGINE: level = se_bit;
            `SRC_BUS: level = bus_bit;
            `SRC_CLK: level = clk_bit;
            default: level = 1'b0;
        endcase
    end

    always_comb begin
        style_eff = (style == DRV_PUMP && !hv_ok) ? DRV_OPEN_DRAIN : style;
        unique case (style_eff)
            DRV_WEAK_PD: oe = 1'b0;
            DRV_STRONG_VDD, DRV_STRONG_VP, DRV_PUMP: oe = 1'b1;
            DRV_OPEN_DRAIN, DRV_WEAK_VDD, DRV_WEAK_VP, DRV_STRONG_PD: oe = !level;
        endcase
    end
endmodule

// File: supply_sequencing_engine.sv
/*
  supply sequencing engine: program store of state definitions, the
  three exit detectors, fault latch and ten driver outputs.
  assumes a 10 MHz mclk; supply_ok, sfd_status and sec_warn are pins;
  prog, nv, bus and adc_warn inputs come from logic on mclk.
*/
`timescale 1ns/1ps
`include "seq_consts.svh"

module supply_sequencing_engine #(
    parameter int N_STATES = `NUM_STATES,
    parameter int TICK_CYCLES = `TICK_CYC
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic ce,
    // power-up and stored configuration
    input wire logic supply_ok,
    input wire logic nv_programmed,
    input wire logic [2*`NUM_OUT-1:0] nv_src_cfg,
    input wire logic [3*`NUM_OUT-1:0] nv_style_cfg,
    // program store write port
    input wire logic prog_we,
    input wire logic [`ST_IDX_W-1:0] prog_addr,
    input wire seq_pkg::state_def_t prog_def,
    // monitored inputs
    input wire logic [`NUM_IN-1:0] sfd_status,
    input wire logic adc_warn,
    input wire logic sec_warn,
    // management bus controls
    input wire logic jump_cmd,
    input wire logic [`NUM_OUT-1:0] bus_out_data,
    input wire logic fault_clear,
    // driver outputs
    output logic [`NUM_OUT-1:0] driver_output_n,
    output logic [`NUM_OUT-1:0] driver_oe,
    output logic [`NUM_OUT-1:0] weak_pulldown,
    output logic [3*`NUM_OUT-1:0] drive_style,
    // status
    output logic [`ST_IDX_W-1:0] cur_state,
    output logic [`NUM_IN-1:0] fault_latch,
    output logic warning,
    output logic config_latched
);
    import seq_pkg::*;

    localparam int STEP_LIM = `STEP_MAX_CYC;
    localparam int LOAD_N = `LOAD_CYC;

    if (N_STATES < 1 || N_STATES > `NUM_STATES) begin : g_bad_states
        $error("N_STATES out of range");
    end
    if (TICK_CYCLES < 1 || TICK_CYCLES > 127) begin : g_bad_tick
        $error("TICK_CYCLES out of range");
    end
    if (`LOAD_CYC > `STEP_MAX_CYC) begin : g_bad_load
        $error("state load slower than allowed step time");
    end

    function automatic logic ge_dly(input logic [`DLY_W-1:0] cnt,
                                    input logic [`DLY_W-1:0] dly);
        ge_dly = (cnt >= dly);
    endfunction

    function automatic logic [`DLY_W-1:0] sat_inc(input logic [`DLY_W-1:0] v);
        sat_inc = (v == `DLY_W'(`MAX_DLY_TICKS)) ? v : v + `DLY_W'(1);
    endfunction

    // input synchronisers
    logic [`NUM_IN-1:0] sfd_meta, sfd_sync;
    logic sup_meta, sup_sync, sec_meta, sec_sync;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            sfd_meta <= '0;
            sfd_sync <= '0;
            sup_meta <= 1'b0;
            sup_sync <= 1'b0;
            sec_meta <= 1'b0;
            sec_sync <= 1'b0;
        end else if (ce) begin
            sfd_meta <= sfd_status;
            sfd_sync <= sfd_meta;
            sup_meta <= supply_ok;
            sup_sync <= sup_meta;
            sec_meta <= sec_warn;
            sec_sync <= sec_meta;
        end
    end

    logic warn_any;
    assign warn_any = adc_warn | sec_sync;

    // program store
    state_def_t prog_mem [0:`NUM_STATES-1];
    always_ff @(posedge mclk) begin
        if (ce && prog_we && int'(prog_addr) < N_STATES) begin
            prog_mem[prog_addr] <= prog_def;
        end
    end

    // engine
    engine_st_t eng_reg;
    state_def_t def_reg;
    logic [`ST_IDX_W-1:0] idx_reg;
    logic [1:0] load_cnt;
    logic cfg_done_reg;
    logic [2*`NUM_OUT-1:0] src_cfg_reg;
    logic [3*`NUM_OUT-1:0] style_cfg_reg;
    logic [6:0] pre_reg;
    logic tick;
    logic [`DLY_W-1:0] seq_cnt, tmo_cnt;
    logic jump_pend;

    logic seq_match, seq_hit, tmo_hit, mon_hit, run;
    logic [`NUM_IN-1:0] deviate;
    logic [`ST_IDX_W-1:0] next_idx;
    logic take_exit;

    assign run = (eng_reg == ENG_RUN);
    assign deviate = (sfd_sync ^ def_reg.mon_expect) & def_reg.mon_mask;
    assign seq_match = (def_reg.seq_sel == `SEL_WARN) ? (warn_any == def_reg.seq_pol)
        : (def_reg.seq_sel < `SEL_W'(`NUM_IN)) ?
          (sfd_sync[def_reg.seq_sel] == def_reg.seq_pol) : 1'b0;
    assign seq_hit = (seq_match && ge_dly(seq_cnt, def_reg.seq_dly)) || jump_pend;
    assign tmo_hit = def_reg.tmo_en && ge_dly(tmo_cnt, def_reg.tmo_dly);
    assign mon_hit = (|deviate) || (def_reg.mon_warn_en && warn_any);
    assign take_exit = run && (mon_hit || tmo_hit || seq_hit);

    always_comb begin
        if (mon_hit) begin
            next_idx = def_reg.mon_next;
        end else if (tmo_hit) begin
            next_idx = def_reg.tmo_next;
        end else begin
            next_idx = def_reg.seq_next;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            eng_reg <= ENG_OFF;
            idx_reg <= `FIRST_STATE;
            load_cnt <= '0;
            cfg_done_reg <= 1'b0;
            src_cfg_reg <= '0;
            style_cfg_reg <= '0;
            def_reg <= '0;
        end else if (ce) begin
            unique case (eng_reg)
                ENG_OFF: begin
                    if (sup_sync) begin
                        eng_reg <= ENG_CFG;
                    end
                end
                ENG_CFG: begin
                    if (!sup_sync) begin
                        eng_reg <= ENG_OFF;
                    end else if (nv_programmed) begin
                        src_cfg_reg <= nv_src_cfg;
                        style_cfg_reg <= nv_style_cfg;
                        cfg_done_reg <= 1'b1;
                        idx_reg <= `FIRST_STATE;
                        load_cnt <= '0;
                        eng_reg <= ENG_LOAD;
                    end
                end
                ENG_LOAD: begin
                    if (load_cnt == 2'd0) begin
                        def_reg <= prog_mem[idx_reg];
                    end
                    if (int'(load_cnt) == LOAD_N - 1) begin
                        eng_reg <= ENG_RUN;
                    end
                    load_cnt <= load_cnt + 2'd1;
                end
                ENG_RUN: begin
                    if (!sup_sync) begin
                        eng_reg <= ENG_OFF;
                        cfg_done_reg <= 1'b0;
                        src_cfg_reg <= '0;
                        style_cfg_reg <= '0;
                    end else if (take_exit) begin
                        idx_reg <= (int'(next_idx) < N_STATES) ? next_idx : idx_reg;
                        load_cnt <= '0;
                        eng_reg <= ENG_LOAD;
                    end
                end
            endcase
        end
    end

    // delay timers in 10 us ticks
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pre_reg <= '0;
        end else if (ce) begin
            pre_reg <= (!run || int'(pre_reg) == TICK_CYCLES - 1) ? 7'h00 : pre_reg + 7'h01;
        end
    end
    assign tick = run && (int'(pre_reg) == TICK_CYCLES - 1);

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            seq_cnt <= '0;
        end else if (ce) begin
            if (!run || !seq_match) begin
                seq_cnt <= '0;
            end else if (tick) begin
                seq_cnt <= sat_inc(seq_cnt);
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            tmo_cnt <= '0;
        end else if (ce) begin
            if (!run) begin
                tmo_cnt <= '0;
            end else if (tick) begin
                tmo_cnt <= sat_inc(tmo_cnt);
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            jump_pend <= 1'b0;
        end else if (ce) begin
            if (jump_cmd && cfg_done_reg) begin
                jump_pend <= 1'b1;
            end else if (take_exit) begin
                jump_pend <= 1'b0;
            end
        end
    end

    // fault latch
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            fault_latch <= '0;
        end else if (ce) begin
            fault_latch <= (fault_clear ? '0 : fault_latch) |
                ((run && def_reg.latch_en) ? deviate : '0);
        end
    end

    // 100 kHz clock
    logic [5:0] aux_cnt;
    logic aux_clk;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            aux_cnt <= '0;
            aux_clk <= 1'b0;
        end else if (ce) begin
            if (int'(aux_cnt) == `AUXCLK_HALF - 1) begin
                aux_cnt <= '0;
                aux_clk <= !aux_clk;
            end else begin
                aux_cnt <= aux_cnt + 6'h01;
            end
        end
    end

    // driver outputs
    logic [`NUM_OUT-1:0] lvl_next, oe_next;
    drive_style_t sty_next [`NUM_OUT];
    logic [3*`NUM_OUT-1:0] sty_flat;
    logic hv_bad;

    for (genvar i = 0; i < `NUM_OUT; i++) begin : g_out
        driver_output_mux u_mux (
            .src_sel(src_cfg_reg[2*i +: 2]),
            .style(drive_style_t'(style_cfg_reg[3*i +: 3])),
            .hv_ok(i < `NUM_HV_OUT),
            .se_bit(def_reg.out_levels[i]),
            .bus_bit(bus_out_data[i]),
            .clk_bit(aux_clk),
            .level(lvl_next[i]),
            .oe(oe_next[i]),
            .style_eff(sty_next[i])
        );
        assign sty_flat[3*i +: 3] = sty_next[i];
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            driver_output_n <= '0;
            driver_oe <= '0;
            weak_pulldown <= '1;
            drive_style <= '0;
        end else if (ce) begin
            driver_output_n <= cfg_done_reg ? lvl_next : '0;
            driver_oe <= cfg_done_reg ? oe_next : '0;
            weak_pulldown <= cfg_done_reg ? '0 : '1;
            drive_style <= cfg_done_reg ? sty_flat : '0;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cur_state <= '0;
            warning <= 1'b0;
            config_latched <= 1'b0;
        end else if (ce) begin
            cur_state <= idx_reg;
            warning <= warn_any;
            config_latched <= cfg_done_reg;
        end
    end

    always_comb begin
        hv_bad = 1'b0;
        for (int k = `NUM_HV_OUT; k < `NUM_OUT; k++) begin
            hv_bad = hv_bad | (drive_style[3*k +: 3] == DRV_PUMP);
        end
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);

    mon_first_a: assert property (ce && take_exit && mon_hit && sup_sync &&
        int'(def_reg.mon_next) < N_STATES |=> idx_reg == $past(def_reg.mon_next))
        else $error("monitor exit not taken first");
    tmo_second_a: assert property (ce && take_exit && !mon_hit && tmo_hit && sup_sync &&
        int'(def_reg.tmo_next) < N_STATES |=> idx_reg == $past(def_reg.tmo_next))
        else $error("timeout exit wrong target");
    jump_adv_a: assert property (ce && take_exit && jump_pend && !mon_hit && !tmo_hit &&
        sup_sync && int'(def_reg.seq_next) < N_STATES
        |=> idx_reg == $past(def_reg.seq_next))
        else $error("jump did not advance");
    step_time_a: assert property (ce && eng_reg == ENG_RUN && take_exit && sup_sync
        |=> eng_reg == ENG_LOAD ##1 eng_reg == ENG_LOAD ##1 (!ce || eng_reg == ENG_RUN))
        else $error("state change too slow");
    seq_restart_a: assert property (ce && run && !seq_match |=> seq_cnt == '0)
        else $error("sequence timer not restarted");
    seq_hold_a: assert property (run && seq_hit && !jump_pend
        |-> seq_match && seq_cnt >= def_reg.seq_dly)
        else $error("sequence exit before delay");
    latch_keep_a: assert property (ce && !fault_clear
        |=> (fault_latch & $past(fault_latch)) == $past(fault_latch))
        else $error("fault latch bit lost");
    unprog_low_a: assert property (ce && !cfg_done_reg
        |=> weak_pulldown == '1 && driver_oe == '0)
        else $error("unprogrammed output not weak low");
    hv_only_a: assert property (!hv_bad)
        else $error("charge pump on upper output");
    mon_fast_a: assert property (ce && run && sup_sync && |deviate |=> eng_reg == ENG_LOAD)
        else $error("monitor exit delayed");

    mon_exit_c: cover property (run && mon_hit);
    tmo_exit_c: cover property (run && !mon_hit && tmo_hit);
    seq_dly_c: cover property (run && seq_match && seq_cnt != '0 && seq_hit);
    jump_c: cover property (run && jump_pend && !mon_hit && !tmo_hit);
endmodule

// File: supply_rail_model.sv
/*
  behavioural model of the supplies around the sequencing engine: each
  rail ramps after its enable and reports okay to its fault detector.
  assumes enables are the engine driver levels and fail is set by the bench.
*/
`timescale 1ns/1ps
`include "seq_consts.svh"

module supply_rail_model #(
    parameter int RAMP = 4
) (
    // clock
    input wire logic mclk,
    // rail enables and injected faults
    input wire logic [`NUM_IN-1:0] enable,
    input wire logic [`NUM_IN-1:0] fail,
    // detector results, 1 = rail okay
    output logic [`NUM_IN-1:0] status
);
    int ramp_cnt [`NUM_IN] = '{default: 0};

    // rail ramps up while enabled, decays when disabled
    always @(posedge mclk) begin
        for (int i = 0; i < `NUM_IN; i++) begin
            if (enable[i] && ramp_cnt[i] < RAMP) begin
                ramp_cnt[i] <= ramp_cnt[i] + 1;
            end else if (!enable[i] && ramp_cnt[i] > 0) begin
                ramp_cnt[i] <= ramp_cnt[i] - 1;
            end
        end
    end

    // okay only at full level and with no injected fault
    always_comb begin
        for (int i = 0; i < `NUM_IN; i++) begin
            status[i] = (ramp_cnt[i] == RAMP) && !fail[i];
        end
    end
endmodule

// File: supply_sequencing_engine_tb.sv
/*
  testbench of the supply sequencing engine: programs a short power-up
  program and walks it through sequence, timeout, monitor and jump exits.
  assumes supply_rail_model closes the loop from driver levels to detectors.
*/
`timescale 1ns/1ps
`include "seq_consts.svh"

module supply_sequencing_engine_tb;
    import seq_pkg::*;

    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic supply_ok = 1'b0;
    logic nv_programmed = 1'b0;
    logic [19:0] src_cfg = 20'he_4000;
    logic [29:0] style_cfg;
    logic prog_we = 1'b0;
    logic [5:0] prog_addr = 6'h00;
    state_def_t prog_def = '0;
    logic [9:0] fail = 10'h000;
    logic [9:0] supply_fault_detector;
    logic adc_warn = 1'b0;
    logic sec_warn = 1'b0;
    logic jump_cmd = 1'b0;
    logic [9:0] bus_out_data = 10'h080;
    logic fault_clear = 1'b0;
    logic [9:0] driver_output_n;
    logic [9:0] driver_oe;
    logic [9:0] weak_pulldown;
    logic [29:0] drive_style;
    logic [5:0] cur_state;
    logic [9:0] fault_latch;
    logic warning;
    logic config_latched;
    int fails = 0;
    int checks_done = 0;
    int toggles;
    logic prev_clk_bit;

    always #50 mclk = ~mclk;

    supply_sequencing_engine #(.TICK_CYCLES(2)) dut (
        .mclk(mclk), .rst_b(rst_b), .ce(1'b1), .supply_ok(supply_ok),
        .nv_programmed(nv_programmed), .nv_src_cfg(src_cfg), .nv_style_cfg(style_cfg),
        .prog_we(prog_we), .prog_addr(prog_addr), .prog_def(prog_def),
        .sfd_status(supply_fault_detector), .adc_warn(adc_warn), .sec_warn(sec_warn),
        .jump_cmd(jump_cmd), .bus_out_data(bus_out_data), .fault_clear(fault_clear),
        .driver_output_n(driver_output_n), .driver_oe(driver_oe),
        .weak_pulldown(weak_pulldown), .drive_style(drive_style),
        .cur_state(cur_state), .fault_latch(fault_latch), .warning(warning),
        .config_latched(config_latched)
    );

    supply_rail_model #(.RAMP(4)) rails (
        .mclk(mclk), .enable(driver_output_n), .fail(fail), .status(supply_fault_detector)
    );

    task automatic complete_run();
        if (fails == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cycles(input int n);
        repeat (n) @(negedge mclk);
    endtask

    task automatic wait_state(input logic [5:0] s, input int lim);
        int n;
        n = 0;
        while (cur_state !== s && n < lim) begin
            @(negedge mclk);
            n++;
        end
        check(32'(cur_state), 32'(s));
    endtask

    function automatic state_def_t mk(input logic [9:0] lv, input logic [5:0] sn,
            input logic [3:0] sel, input logic pol, input logic [15:0] sd,
            input logic ten, input logic [5:0] tn, input logic [15:0] td,
            input logic [5:0] mn, input logic [9:0] mm, input logic ww, input logic le);
        return '{lv, sn, sel, pol, sd, ten, tn, td, mn, mm, mm, ww, le};
    endfunction

    task automatic prog(input logic [5:0] a, input state_def_t d);
        @(negedge mclk);
        prog_we = 1'b1;
        prog_addr = a;
        prog_def = d;
        @(negedge mclk);
        prog_we = 1'b0;
    endtask

    task automatic pulse_jump();
        @(negedge mclk);
        jump_cmd = 1'b1;
        @(negedge mclk);
        jump_cmd = 1'b0;
    endtask

    initial begin
        style_cfg = {10{3'h1}};
        style_cfg[2:0] = 3'h3;
        style_cfg[20:18] = 3'h7;
        cycles(6);
        check(32'(weak_pulldown), 32'h0000_03ff);
        check(32'(driver_output_n), 32'h0000_0000);
        rst_b = 1'b1;
        prog(6'h00, mk(10'h001, 6'h01, 4'h0, 1'b1, 16'h000a, 1'b0, 6'h00, 16'h0000,
                       6'h00, 10'h000, 1'b0, 1'b0));
        prog(6'h01, mk(10'h003, 6'h3e, 4'h1, 1'b1, 16'h0000, 1'b1, 6'h05, 16'h001e,
                       6'h07, 10'h001, 1'b0, 1'b1));
        prog(6'h3e, mk(10'h007, 6'h02, 4'h9, 1'b1, 16'h0000, 1'b0, 6'h00, 16'h0000,
                       6'h07, 10'h003, 1'b1, 1'b1));
        prog(6'h02, mk(10'h007, 6'h04, 4'hf, 1'b0, 16'h0000, 1'b1, 6'h03, 16'h0003,
                       6'h00, 10'h000, 1'b0, 1'b0));
        prog(6'h03, mk(10'h007, 6'h05, 4'h0, 1'b1, 16'h0000, 1'b1, 6'h04, 16'h0000,
                       6'h07, 10'h000, 1'b1, 1'b0));
        prog(6'h07, mk(10'h000, 6'h00, 4'hf, 1'b1, 16'h0000, 1'b0, 6'h00, 16'h0000,
                       6'h00, 10'h000, 1'b0, 1'b0));
        supply_ok = 1'b1;
        cycles(30);
        check(32'(config_latched), 32'h0000_0000);
        check(32'(weak_pulldown), 32'h0000_03ff);
        nv_programmed = 1'b1;
        for (int n = 0; n < 20 && config_latched !== 1'b1; n++) @(negedge mclk);
        cycles(3);
        check(32'(weak_pulldown), 32'h0000_0000);
        check(32'(driver_output_n & 10'h2ff), 32'h0000_0081);
        check(32'(driver_oe[0]), 32'h0000_0001);
        check(32'(drive_style[20:18]), 32'(DRV_OPEN_DRAIN));
        // sequence input glitch must restart the delay
        for (int n = 0; n < 50 && supply_fault_detector[0] !== 1'b1; n++) @(negedge mclk);
        cycles(8);
        fail[0] = 1'b1;
        cycles(1);
        fail[0] = 1'b0;
        cycles(21);
        check(32'(cur_state), 32'h0000_0000);
        wait_state(6'h01, 20);
        wait_state(6'h3e, 40);
        cycles(1);
        check(32'(driver_output_n[6:0]), 32'h0000_0007);
        pulse_jump();
        wait_state(6'h02, 10);
        wait_state(6'h03, 20);
        adc_warn = 1'b1;
        cycles(2);
        check(32'(warning), 32'h0000_0001);
        wait_state(6'h07, 10);
        sec_warn = 1'b1;
        adc_warn = 1'b0;
        cycles(5);
        check(32'(warning), 32'h0000_0001);
        sec_warn = 1'b0;
        cycles(5);
        check(32'(warning), 32'h0000_0000);
        pulse_jump();
        wait_state(6'h00, 10);
        wait_state(6'h3e, 200);
        check(32'(fault_latch), 32'h0000_0000);
        fail[1] = 1'b1;
        wait_state(6'h07, 8);
        check(32'(fault_latch), 32'h0000_0002);
        @(negedge mclk);
        fault_clear = 1'b1;
        @(negedge mclk);
        fault_clear = 1'b0;
        cycles(2);
        check(32'(fault_latch), 32'h0000_0000);
        toggles = 0;
        prev_clk_bit = driver_output_n[8];
        for (int n = 0; n < 200; n++) begin
            @(negedge mclk);
            if (driver_output_n[8] !== prev_clk_bit) begin
                toggles++;
            end
            prev_clk_bit = driver_output_n[8];
        end
        check(32'(toggles), 32'h0000_0004);
        check(32'(driver_output_n[9]), 32'h0000_0000);
        complete_run();
    end

    initial begin
        repeat (20000) @(posedge mclk);
        fails++;
        complete_run();
    end
endmodule
